// file: gpmc_cfg.svh
// Constants for the power-mode controller: times, limits, message codes.
`ifndef GPMC_CFG_SVH
`define GPMC_CFG_SVH

// ==========================================================
// Clock and timing figures
`define GPMC_CLK_HZ        50000000
`define GPMC_TOGGLE_MIN_MS 1
`define GPMC_PPS_PERIOD_S  1
`define GPMC_PPS_HIGH_MS   200

// ==========================================================
// Configuration messages and periodic-fix period (seconds)
`define GPMC_MSG_ADC       8'h97
`define GPMC_MSG_PF        8'ha7
`define GPMC_PF_DEF_S      13'h0708
`define GPMC_PF_MIN_S      13'h000a
`define GPMC_PF_MAX_S      13'h1c20

// ==========================================================
// Adaptive duty-cycle phase lengths (milliseconds)
`define GPMC_ON_MS_L3      10'h0c8
`define GPMC_ON_MS_L2      10'h1c2
`define GPMC_ON_MS_L1      10'h2bc
`define GPMC_ON_MS_L0      10'h384
`define GPMC_CPU_MS        10'h064
`define GPMC_STBY_MS       10'h12c

// ==========================================================
// Signal-strength codes
`define GPMC_SIG_NONE      2'h0
`define GPMC_SIG_L1        2'h1
`define GPMC_SIG_L2        2'h2
`define GPMC_SIG_PF_MIN    2'h2

`endif

// file: gpmc_checker_assertions.sv
// Port-level checker of the power-mode controller.
`timescale 1ns/1ps

module gpmc_checker #(
   parameter int SEC_CYC      = 200,
   parameter int PPS_HIGH_CYC = 40
) (
   input wire logic                clk_in,
   input wire logic                nrst_in,
   input wire logic                ext_reset_n_in,
   input wire logic                acq_done_in,
   input wire logic                cfg_valid_in,
   input wire logic [7:0]          cfg_id_in,
   input wire logic                cfg_enable_in,
   input wire logic [31:0]         ret_rdata_out,
   input wire logic                mode_flag_out,
   input wire logic                tracking_out,
   input wire logic                wake_pulse_out,
   input wire logic                pulse_per_second_out,
   input wire logic [31:0]         rtc_seconds_out,
   input wire gpmc_pkg::gpmc_pwr_t power_domains_out,
   input wire logic                adaptive_duty_cycle_mode_out,
   input wire logic                periodic_fix_mode_out
);
   // ==========================================================
   // One clock domain, so clocking and disable are shared
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);

   // ==========================================================
   // Power state and domains
   a_hib_domains: assert property (!mode_flag_out |->
      power_domains_out == 4'h1) else $error("hibernate domains wrong");
   a_aon_kept: assert property (power_domains_out.aon)
      else $error("always-on domain dropped");
   a_hib_no_track: assert property (!mode_flag_out |-> !tracking_out)
      else $error("tracking while hibernating");
   a_acq_to_track: assert property (mode_flag_out && !tracking_out &&
      power_domains_out == 4'hf && acq_done_in |=> tracking_out)
      else $error("acquisition did not move to tracking");
   // Wake pulse after reset lands within two edges and lasts one cycle
   a_wake_after_por: assert property ($rose(nrst_in) |->
      ##[0:1] wake_pulse_out) else $error("no wake pulse after reset");
   a_wake_single: assert property (wake_pulse_out |=> !wake_pulse_out)
      else $error("wake pulse longer than one cycle");

   // ==========================================================
   // Timing pulse, external clear and configuration
   a_pps_period: assert property ($rose(pulse_per_second_out) |->
      ##SEC_CYC $rose(pulse_per_second_out)) else $error("pps period wrong");
   a_pps_width: assert property ($rose(pulse_per_second_out) |->
      ##PPS_HIGH_CYC $fell(pulse_per_second_out))
      else $error("pps width wrong");
   a_ext_clear: assert property (!ext_reset_n_in [*7] |->
      rtc_seconds_out == 32'h0 && ret_rdata_out == 32'h0)
      else $error("external reset did not clear retained state");
   a_cfg_adapt: assert property (cfg_valid_in && cfg_id_in == 8'h97 &&
      cfg_enable_in |=> ##1
      adaptive_duty_cycle_mode_out && !periodic_fix_mode_out)
      else $error("adaptive message not applied");
   a_cfg_pfix: assert property (cfg_valid_in && cfg_id_in == 8'ha7 &&
      cfg_enable_in |=> ##1
      periodic_fix_mode_out && !adaptive_duty_cycle_mode_out)
      else $error("periodic message not applied");

   // Main scenarios reached
   c_track: cover property ($rose(tracking_out));
   c_cpu_only: cover property (power_domains_out == 4'h9);
   c_hib_entry: cover property ($fell(mode_flag_out));
endmodule

// file: gpmc_host_model.sv
// Host model driving the toggle pin and the external reset pin.
`timescale 1ns/1ps

module gpmc_host_model (
   input  wire logic        clk_in,
   input  wire logic        pulse_in,
   input  wire logic [15:0] width_in,
   input  wire logic        reset_in,
   output logic             power_toggle_out,
   output logic             ext_reset_n_out,
   output logic             busy_out
);
   logic [15:0] hi_left  = 16'h0;
   logic [15:0] lo_left  = 16'h0;
   logic [3:0]  rst_left = 4'h0;

   // High for width cycles, then low as long; a busy host ignores requests
   always_ff @(posedge clk_in) begin
      if (pulse_in && !busy_out) begin
         hi_left <= width_in;
         lo_left <= width_in;
      end else if (hi_left != 16'h0) begin
         hi_left <= hi_left - 16'h1;
      end else if (lo_left != 16'h0) begin
         lo_left <= lo_left - 16'h1;
      end
      if (reset_in && !busy_out) begin
         rst_left <= 4'h8;
      end else if (rst_left != 4'h0) begin
         rst_left <= rst_left - 4'h1;
      end
   end

   // GPIO drives both pins actively, so no floating level is modelled
   assign power_toggle_out = (hi_left != 16'h0);
   assign ext_reset_n_out  = (rst_left == 4'h0);
   assign busy_out = (hi_left != 16'h0) || (lo_left != 16'h0) ||
                     (rst_left != 4'h0);
endmodule

// file: gpmc_pkg.sv
// Types shared by the power-mode controller files.
package gpmc_pkg;

   // ==========================================================
   // Sequencer states
   typedef enum logic [2:0] {
      st_hib,
      st_acq,
      st_track,
      st_cpu,
      st_stby
   } gpmc_state_t;

   // ==========================================================
   // Power-domain enables
   typedef struct packed {
      logic core;
      logic dsp;
      logic rf;
      logic aon;
   } gpmc_pwr_t;

endpackage

// file: gpmc_power_mode_controller_test.sv
// Self-checking testbench of the power-mode controller.
`timescale 1ns/1ps

module gpmc_power_mode_controller_test;
   // ==========================================================
   // Signals
   logic                clk_in, nrst_in, acq_done_in, fix_done_in;
   logic                position_req_in, cfg_valid_in, cfg_enable_in;
   logic [1:0]          signal_level_in;
   logic [7:0]          cfg_id_in;
   logic [12:0]         cfg_period_in;
   logic                ret_wr_in, power_toggle_in, ext_reset_n_in;
   logic [3:0]          ret_addr_in;
   logic [31:0]         ret_wdata_in, ret_rdata_out, rtc_seconds_out;
   logic                host_pulse, host_rst, host_busy;
   logic [15:0]         host_width;
   logic                mode_flag_out, tracking_out, wake_pulse_out;
   logic                fast_fix_out, pulse_per_second_out;
   logic                adaptive_duty_cycle_mode_out, periodic_fix_mode_out;
   gpmc_pkg::gpmc_pwr_t power_domains_out;
   int                  num_errors, comparisons;

   // Counts shortened so the run stays brief
   gpmc_top #(.TOGGLE_MIN_CYC(20), .SEC_CYC(200), .PPS_HIGH_CYC(40),
      .MS_CYC(10)) DUT (
      .clk_in(clk_in), .nrst_in(nrst_in), .power_toggle_in(power_toggle_in),
      .ext_reset_n_in(ext_reset_n_in), .acq_done_in(acq_done_in),
      .fix_done_in(fix_done_in), .position_req_in(position_req_in),
      .signal_level_in(signal_level_in), .cfg_valid_in(cfg_valid_in),
      .cfg_id_in(cfg_id_in), .cfg_enable_in(cfg_enable_in),
      .cfg_period_in(cfg_period_in), .ret_wr_in(ret_wr_in),
      .ret_addr_in(ret_addr_in), .ret_wdata_in(ret_wdata_in),
      .ret_rdata_out(ret_rdata_out), .mode_flag_out(mode_flag_out),
      .tracking_out(tracking_out), .wake_pulse_out(wake_pulse_out),
      .fast_fix_out(fast_fix_out),
      .pulse_per_second_out(pulse_per_second_out),
      .rtc_seconds_out(rtc_seconds_out),
      .power_domains_out(power_domains_out),
      .adaptive_duty_cycle_mode_out(adaptive_duty_cycle_mode_out),
      .periodic_fix_mode_out(periodic_fix_mode_out));

   gpmc_host_model host (.clk_in(clk_in), .pulse_in(host_pulse),
      .width_in(host_width), .reset_in(host_rst),
      .power_toggle_out(power_toggle_in), .ext_reset_n_out(ext_reset_n_in),
      .busy_out(host_busy));

   // 50 MHz clock
   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end

   // ==========================================================
   // Shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Host pulse or external reset, then wait for the host to go idle
   task automatic host_cmd(input logic rst, input logic [15:0] w);
      @(posedge clk_in);
      host_pulse <= !rst;
      host_rst <= rst;
      host_width <= w;
      @(posedge clk_in);
      host_pulse <= 1'b0;
      host_rst <= 1'b0;
      for (int i = 0; i < 400; i++) begin
         @(posedge clk_in);
         #1;
         if (host_busy !== 1'b1) break;
      end
   endtask

   task automatic strobe(input int k);
      @(posedge clk_in);
      acq_done_in <= (k == 0);
      fix_done_in <= (k == 1);
      position_req_in <= (k == 2);
      @(posedge clk_in);
      acq_done_in <= 1'b0;
      fix_done_in <= 1'b0;
      position_req_in <= 1'b0;
      #1;
   endtask

   task automatic cfg(input logic [7:0] id, input logic en,
                      input logic [12:0] per);
      @(posedge clk_in);
      cfg_valid_in <= 1'b1;
      cfg_id_in <= id;
      cfg_enable_in <= en;
      cfg_period_in <= per;
      @(posedge clk_in);
      cfg_valid_in <= 1'b0;
      // Mode outputs follow the stored enables one edge later
      @(posedge clk_in);
      #1;
   endtask

   // Waits for the domains to change on their own, then checks them
   task automatic wait_dom(input logic [3:0] exp, input int max);
      logic [3:0] start;
      start = power_domains_out;
      for (int i = 0; i < max; i++) begin
         @(posedge clk_in);
         #1;
         if (power_domains_out !== start) break;
      end
      chk(power_domains_out, exp);
   endtask

   task automatic give_verdict();
      if (num_errors == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_power_up();
      logic seen;
      seen = 1'b0;
      @(posedge clk_in);
      nrst_in <= 1'b1;
      repeat (4) begin
         @(posedge clk_in);
         #1 seen = seen | wake_pulse_out;
      end
      chk(seen, 1'b1);
      chk(mode_flag_out, 1'b0);
      chk(power_domains_out, 4'h1);
   endtask

   task automatic t_toggle();
      host_cmd(1'b0, 16'h000a);
      chk(mode_flag_out, 1'b0);
      host_cmd(1'b0, 16'h001e);
      chk(mode_flag_out, 1'b1);
      chk(power_domains_out, 4'hf);
      chk(tracking_out, 1'b0);
      strobe(0);
      chk(tracking_out, 1'b1);
      host_cmd(1'b0, 16'h003c);
      chk(mode_flag_out, 1'b0);
      chk(power_domains_out, 4'h1);
   endtask

   task automatic t_ext_reset();
      @(posedge clk_in);
      ret_wr_in <= 1'b1;
      ret_addr_in <= 4'h3;
      ret_wdata_in <= 32'h5a5a_c3c3;
      @(posedge clk_in);
      ret_wr_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      #1 chk(ret_rdata_out, 32'h5a5a_c3c3);
      chk(rtc_seconds_out != 32'h0, 1'b1);
      host_cmd(1'b1, 16'h0);
      chk(ret_rdata_out, 32'h0);
      chk(rtc_seconds_out, 32'h0);
   endtask

   task automatic t_config();
      cfg(8'h97, 1'b0, 13'h0);
      chk(adaptive_duty_cycle_mode_out, 1'b0);
      cfg(8'h97, 1'b1, 13'h0);
      chk(adaptive_duty_cycle_mode_out, 1'b1);
      cfg(8'h42, 1'b1, 13'h0);
      chk(adaptive_duty_cycle_mode_out, 1'b1);
      cfg(8'ha7, 1'b1, 13'h0005);
      chk(periodic_fix_mode_out, 1'b1);
      chk(adaptive_duty_cycle_mode_out, 1'b0);
   endtask

   // Period 5 is clamped to 10 s, so no wake may come before 1700 cycles
   task automatic t_periodic();
      strobe(2);
      chk(mode_flag_out, 1'b1);
      chk(fast_fix_out, 1'b0);
      strobe(0);
      strobe(1);
      chk(mode_flag_out, 1'b0);
      // Store retained data so the timed wake may use a fast fix
      @(posedge clk_in);
      ret_wr_in <= 1'b1;
      @(posedge clk_in);
      ret_wr_in <= 1'b0;
      repeat (1700) @(posedge clk_in);
      #1 chk(mode_flag_out, 1'b0);
      wait_dom(4'hf, 700);
      chk(fast_fix_out, 1'b1);
      strobe(0);
      strobe(1);
      @(posedge clk_in);
      signal_level_in <= 2'h1;
      repeat (2600) @(posedge clk_in);
      #1 chk(mode_flag_out, 1'b0);
   endtask

   task automatic t_adaptive();
      @(posedge clk_in);
      signal_level_in <= 2'h3;
      cfg(8'h97, 1'b1, 13'h0);
      host_cmd(1'b0, 16'h001e);
      strobe(0);
      wait_dom(4'h9, 2300);
      wait_dom(4'h1, 1300);
      chk(mode_flag_out, 1'b1);
      @(posedge clk_in);
      signal_level_in <= 2'h0;
      wait_dom(4'hf, 3300);
      repeat (2500) @(posedge clk_in);
      #1 chk(power_domains_out, 4'hf);
      wait_dom(4'h1, 7000);
   endtask

   // ==========================================================
   // Main sequence and watchdog
   initial begin
      num_errors = 0;
      comparisons = 0;
      {nrst_in, acq_done_in, fix_done_in, position_req_in} = 4'h0;
      {cfg_valid_in, cfg_enable_in, ret_wr_in} = 3'h0;
      {host_pulse, host_rst, host_width} = 18'h0;
      signal_level_in = 2'h3;
      cfg_id_in = 8'h0;
      cfg_period_in = 13'h0;
      ret_addr_in = 4'h0;
      ret_wdata_in = 32'h0;
      repeat (16) @(posedge clk_in);
      t_power_up();
      t_toggle();
      t_ext_reset();
      t_config();
      t_periodic();
      t_adaptive();
      give_verdict();
   end

   // Whole run needs about 20000 cycles
   initial begin
      repeat (60000) @(posedge clk_in);
      num_errors++;
      give_verdict();
   end
endmodule

bind gpmc_top gpmc_checker #(.SEC_CYC(SEC_CYC),
   .PPS_HIGH_CYC(PPS_HIGH_CYC)) u_chk (
   .clk_in(clk_in), .nrst_in(nrst_in), .ext_reset_n_in(ext_reset_n_in),
   .acq_done_in(acq_done_in), .cfg_valid_in(cfg_valid_in),
   .cfg_id_in(cfg_id_in), .cfg_enable_in(cfg_enable_in),
   .ret_rdata_out(ret_rdata_out), .mode_flag_out(mode_flag_out),
   .tracking_out(tracking_out), .wake_pulse_out(wake_pulse_out),
   .pulse_per_second_out(pulse_per_second_out),
   .rtc_seconds_out(rtc_seconds_out), .power_domains_out(power_domains_out),
   .adaptive_duty_cycle_mode_out(adaptive_duty_cycle_mode_out),
   .periodic_fix_mode_out(periodic_fix_mode_out));

// file: gpmc_ret_mem.sv
// Retained battery-backed RAM with a whole-array clear.
`timescale 1ns/1ps

module gpmc_ret_mem #(
   parameter int unsigned DEPTH = 16,
   parameter int unsigned WIDTH = 32,
   parameter int unsigned AW    = $clog2(DEPTH)
) (
   input  wire logic             clk_in,
   input  wire logic             nrst_in,
   input  wire logic             clr_in,
   input  wire logic             wr_in,
   input  wire logic [AW-1:0]    addr_in,
   input  wire logic [WIDTH-1:0] wdata_in,
   output logic      [WIDTH-1:0] rdata_out
);

   logic [WIDTH-1:0] mem [DEPTH];

   // ==========================================================
   // Storage, one entry per generate step
   for (genvar g = 0; g < DEPTH; g++) begin : g_entry
      wire logic hit = wr_in && (addr_in == AW'(g));
      // Clear beats a write so no stale word survives a reset
      always_ff @(posedge clk_in or negedge nrst_in) begin
         if (!nrst_in) begin
            mem[g] <= '0;
         end else if (clr_in) begin
            mem[g] <= '0;
         end else if (hit) begin
            mem[g] <= wdata_in;
         end
      end
   end

   // ==========================================================
   // Registered read port
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rdata_out <= '0;
      end else begin
         rdata_out <= clr_in ? '0 : mem[addr_in];
      end
   end

endmodule

// file: gpmc_top.sv
// Power-mode sequencer of the positioning receiver.
`timescale 1ns/1ps
`include "gpmc_cfg.svh"

module gpmc_top #(
   parameter int unsigned TOGGLE_MIN_CYC =
      `GPMC_TOGGLE_MIN_MS * (`GPMC_CLK_HZ / 1000),
   parameter int unsigned SEC_CYC  = `GPMC_PPS_PERIOD_S * `GPMC_CLK_HZ,
   parameter int unsigned PPS_HIGH_CYC =
      `GPMC_PPS_HIGH_MS * (`GPMC_CLK_HZ / 1000),
   parameter int unsigned MS_CYC   = `GPMC_CLK_HZ / 1000,
   parameter int unsigned MEM_DEPTH = 16,
   parameter int unsigned MEM_WIDTH = 32,
   parameter int unsigned MEM_AW    = $clog2(MEM_DEPTH)
) (
   input  wire logic                 clk_in,
   input  wire logic                 nrst_in,
   input  wire logic                 power_toggle_in,
   input  wire logic                 ext_reset_n_in,
   input  wire logic                 acq_done_in,
   input  wire logic                 fix_done_in,
   input  wire logic                 position_req_in,
   input  wire logic [1:0]           signal_level_in,
   input  wire logic                 cfg_valid_in,
   input  wire logic [7:0]           cfg_id_in,
   input  wire logic                 cfg_enable_in,
   input  wire logic [12:0]          cfg_period_in,
   input  wire logic                 ret_wr_in,
   input  wire logic [MEM_AW-1:0]    ret_addr_in,
   input  wire logic [MEM_WIDTH-1:0] ret_wdata_in,
   output logic      [MEM_WIDTH-1:0] ret_rdata_out,
   output logic                      mode_flag_out,
   output logic                      tracking_out,
   output logic                      wake_pulse_out,
   output logic                      fast_fix_out,
   output logic                      pulse_per_second_out,
   output logic [31:0]               rtc_seconds_out,
   output gpmc_pkg::gpmc_pwr_t       power_domains_out,
   output logic                      adaptive_duty_cycle_mode_out,
   output logic                      periodic_fix_mode_out
);

   // ==========================================================
   // Pin synchronisers
   logic [2:0] tog_sync;
   logic [2:0] rst_sync;
   logic       tog_lvl;
   logic       erst_lvl;

   // Three stages; a level counts once stages two and three agree
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         tog_sync <= 3'h0;
         rst_sync <= 3'h7;
         tog_lvl  <= 1'b0;
         erst_lvl <= 1'b1;
      end else begin
         tog_sync <= {tog_sync[1:0], power_toggle_in};
         rst_sync <= {rst_sync[1:0], ext_reset_n_in};
         if (tog_sync[2] == tog_sync[1]) tog_lvl <= tog_sync[2];
         if (rst_sync[2] == rst_sync[1]) erst_lvl <= rst_sync[2];
      end
   end

   wire logic ret_clear = !erst_lvl;

   // ==========================================================
   // Toggle width qualifier
   logic        tog_prev;
   logic        tog_armed;
   logic [31:0] tog_cnt;
   wire  logic  tog_rise   = tog_lvl && !tog_prev;
   wire  logic  tog_accept = tog_armed && tog_lvl &&
                             (tog_cnt == TOGGLE_MIN_CYC - 1);

   // A level that drops before the minimum width is discarded, so
   // glitches on the pull-up never flip the mode
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         tog_prev  <= 1'b0;
         tog_armed <= 1'b0;
         tog_cnt   <= 32'h0;
      end else begin
         tog_prev <= tog_lvl;
         if (tog_rise) begin
            tog_armed <= 1'b1;
            tog_cnt   <= 32'h1; // Rise cycle is the first high cycle
         end else if (!tog_lvl || tog_accept) begin
            tog_armed <= 1'b0;
         end else if (tog_armed) begin
            tog_cnt <= tog_cnt + 32'h1;
         end
      end
   end

   // ==========================================================
   // Time base: millisecond tick, second tick, RTC
   logic [31:0] ms_cnt;
   logic [31:0] pps_cnt;
   logic [31:0] rtc_sec;
   wire  logic  ms_tick  = (ms_cnt == MS_CYC - 1);
   wire  logic  sec_tick = (pps_cnt == SEC_CYC - 1);

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ms_cnt  <= 32'h0;
         pps_cnt <= 32'h0;
         rtc_sec <= 32'h0;
      end else begin
         ms_cnt  <= ms_tick ? 32'h0 : ms_cnt + 32'h1;
         pps_cnt <= sec_tick ? 32'h0 : pps_cnt + 32'h1;
         if (ret_clear) rtc_sec <= 32'h0;
         else if (sec_tick) rtc_sec <= rtc_sec + 32'h1;
      end
   end

   // ==========================================================
   // Mode configuration from messages
   logic        adc_en;
   logic        pf_en;
   logic [12:0] pf_period;
   wire  logic  cfg_adc = cfg_valid_in && (cfg_id_in == `GPMC_MSG_ADC);
   wire  logic  cfg_pf  = cfg_valid_in && (cfg_id_in == `GPMC_MSG_PF);
   wire  logic [12:0] period_clamped =
      (cfg_period_in < `GPMC_PF_MIN_S) ? `GPMC_PF_MIN_S :
      (cfg_period_in > `GPMC_PF_MAX_S) ? `GPMC_PF_MAX_S : cfg_period_in;

   // The two energy modes exclude each other; enabling one drops the other
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         adc_en    <= 1'b0;
         pf_en     <= 1'b0;
         pf_period <= `GPMC_PF_DEF_S;
      end else if (cfg_adc) begin
         adc_en <= cfg_enable_in;
         if (cfg_enable_in) pf_en <= 1'b0;
      end else if (cfg_pf) begin
         pf_en     <= cfg_enable_in;
         pf_period <= period_clamped;
         if (cfg_enable_in) adc_en <= 1'b0;
      end
   end

   // ==========================================================
   // Phase timing for the adaptive cycle and wake conditions for the periodic fix
   gpmc_pkg::gpmc_state_t state;
   gpmc_pkg::gpmc_state_t next_state;
   logic [9:0]  phase_ms;
   logic [12:0] wake_sec;
   logic        mem_valid;
   wire  logic  sig_none = (signal_level_in == `GPMC_SIG_NONE);
   wire  logic  pf_ok    = pf_en && (signal_level_in >= `GPMC_SIG_PF_MIN);
   wire  logic [9:0] on_ms =
      sig_none                         ? `GPMC_ON_MS_L0 :
      (signal_level_in == `GPMC_SIG_L1) ? `GPMC_ON_MS_L1 :
      (signal_level_in == `GPMC_SIG_L2) ? `GPMC_ON_MS_L2 :
                                          `GPMC_ON_MS_L3;
   wire  logic [9:0] phase_lim =
      (state == gpmc_pkg::st_cpu)  ? `GPMC_CPU_MS :
      (state == gpmc_pkg::st_stby) ? `GPMC_STBY_MS : on_ms;
   wire  logic phase_done = ms_tick && (phase_ms >= phase_lim - 10'h1);
   wire  logic pf_wake = pf_ok && sec_tick &&
                         (wake_sec >= pf_period - 13'h1);
   wire  logic pos_wake = pf_en && position_req_in;

   // ==========================================================
   // Sequencer next state
   always_comb begin
      next_state = state;
      case (state)
         gpmc_pkg::st_hib: begin
            if (tog_accept || pf_wake || pos_wake)
               next_state = gpmc_pkg::st_acq;
         end
         gpmc_pkg::st_acq: begin
            if (tog_accept) next_state = gpmc_pkg::st_hib;
            else if (acq_done_in) next_state = gpmc_pkg::st_track;
         end
         gpmc_pkg::st_track: begin
            if (tog_accept) next_state = gpmc_pkg::st_hib;
            else if (pf_ok && fix_done_in)
               next_state = gpmc_pkg::st_hib;
            else if (adc_en && phase_done)
               next_state = sig_none ? gpmc_pkg::st_stby
                                     : gpmc_pkg::st_cpu;
         end
         gpmc_pkg::st_cpu: begin
            if (tog_accept) next_state = gpmc_pkg::st_hib;
            else if (phase_done) next_state = gpmc_pkg::st_stby;
         end
         gpmc_pkg::st_stby: begin
            if (tog_accept) next_state = gpmc_pkg::st_hib;
            else if (phase_done) next_state = gpmc_pkg::st_track;
         end
         default: next_state = gpmc_pkg::st_hib;
      endcase
   end

   wire logic leave_hib = (state == gpmc_pkg::st_hib) &&
                          (next_state != gpmc_pkg::st_hib);

   // ==========================================================
   // State, phase and wake counters
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state    <= gpmc_pkg::st_hib;
         phase_ms <= 10'h0;
         wake_sec <= 13'h0;
      end else begin
         state <= next_state;
         if (next_state != state) phase_ms <= 10'h0;
         else if (ms_tick) phase_ms <= phase_ms + 10'h1;
         if (state != gpmc_pkg::st_hib || !pf_ok) wake_sec <= 13'h0;
         else if (sec_tick) wake_sec <= wake_sec + 13'h1;
      end
   end

   // Retained data is worth a fast fix only after something was stored;
   // external reset wipes the memory, so its clear wins here
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         mem_valid <= 1'b0;
      end else if (ret_clear) begin
         mem_valid <= 1'b0;
      end else if (ret_wr_in) begin
         mem_valid <= 1'b1;
      end
   end

   // ==========================================================
   // Registered outputs
   logic started;
   wire  logic nh_hib   = (next_state == gpmc_pkg::st_hib);
   wire  logic nh_cpu   = (next_state == gpmc_pkg::st_cpu);
   wire  logic nh_stby  = (next_state == gpmc_pkg::st_stby);
   wire  logic full_dom = !nh_hib && !nh_cpu && !nh_stby;

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         started              <= 1'b0;
         wake_pulse_out       <= 1'b0;
         mode_flag_out        <= 1'b0;
         tracking_out         <= 1'b0;
         fast_fix_out         <= 1'b0;
         pulse_per_second_out <= 1'b0;
         rtc_seconds_out      <= 32'h0;
         power_domains_out    <= '{core: 1'b0, dsp: 1'b0, rf: 1'b0,
                                   aon: 1'b1};
         adaptive_duty_cycle_mode_out <= 1'b0;
         periodic_fix_mode_out        <= 1'b0;
      end else begin
         started        <= 1'b1;
         wake_pulse_out <= !started;
         mode_flag_out  <= !nh_hib;
         tracking_out   <= (next_state == gpmc_pkg::st_track);
         fast_fix_out   <= leave_hib && mem_valid;
         pulse_per_second_out <= (pps_cnt < PPS_HIGH_CYC);
         rtc_seconds_out <= rtc_sec;
         power_domains_out.core <= !nh_hib && !nh_stby;
         power_domains_out.dsp  <= full_dom;
         power_domains_out.rf   <= full_dom;
         power_domains_out.aon  <= 1'b1;
         adaptive_duty_cycle_mode_out <= adc_en;
         periodic_fix_mode_out        <= pf_en;
      end
   end

   // ==========================================================
   // Retained memory
   gpmc_ret_mem #(
      .DEPTH (MEM_DEPTH),
      .WIDTH (MEM_WIDTH),
      .AW    (MEM_AW)
   ) u_ret_mem (
      .clk_in    (clk_in),
      .nrst_in   (nrst_in),
      .clr_in    (ret_clear),
      .wr_in     (ret_wr_in),
      .addr_in   (ret_addr_in),
      .wdata_in  (ret_wdata_in),
      .rdata_out (ret_rdata_out)
   );

endmodule
